// File: verilog/ext_bus_pkg.sv
// Constants, cycle kind and state types for the external memory bus sequencer.
// Assumes a single 100 MHz system clock; bus timing counts in half oscillator periods.
package ext_bus_pkg;

   // ----------------------------------------------------------------
   // Clock and oscillator timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS       = 10;
   localparam int OSC_PERIOD_NS       = 100;
   localparam int HALF_CYCLES         = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int ADDR_FLOAT_MAX_NS   = 10;
   localparam int ADDR_FLOAT_MAX_CYC  = (ADDR_FLOAT_MAX_NS / CLK_PERIOD_NS < 1) ? 1
                                        : ADDR_FLOAT_MAX_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Bus phase marks, in half oscillator periods
   // ----------------------------------------------------------------
   localparam int HALF_W = 5;
   localparam logic [HALF_W-1:0] ALE_HALVES           = 5'h02;
   localparam logic [HALF_W-1:0] ALE_SHORT_HALVES     = 5'h01;
   localparam logic [HALF_W-1:0] FETCH_STROBE_HALVES  = 5'h03;
   localparam logic [HALF_W-1:0] COMPAT_STROBE_HALVES = 5'h06;
   localparam logic [HALF_W-1:0] FAST_STROBE_HALVES   = 5'h02;
   localparam logic [HALF_W-1:0] WAIT_STATE_HALVES    = 5'h02;
   localparam logic [HALF_W-1:0] COMPAT_STROBE_LEAD   = 5'h03;
   localparam logic [HALF_W-1:0] FAST_STROBE_LEAD     = 5'h02;
   localparam logic [HALF_W-1:0] COMPAT_DATA_HOLD     = 5'h02;
   localparam logic [HALF_W-1:0] FAST_DATA_HOLD       = 5'h01;
   localparam logic [HALF_W-1:0] COMPAT_ALE_GAP       = 5'h01;
   localparam logic [HALF_W-1:0] FAST_ALE_GAP         = 5'h02;
   localparam logic [HALF_W-1:0] ALE_TAIL_HALVES      = 5'h02;
   localparam logic [HALF_W-1:0] ADDR_HOLD_HALVES     = 5'h01;

   // ----------------------------------------------------------------
   // Widths, cycle kinds and states
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int WAIT_W = 2;

   typedef enum logic [1:0] {
      KIND_FETCH = 2'b00,
      KIND_READ  = 2'b01,
      KIND_WRITE = 2'b10
   } bus_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01
   } bus_state_t;

endpackage : ext_bus_pkg

// File: verilog/osc_half_tick.sv
// Half oscillator period tick generator for the bus sequencer.
// Assumes clk_in is the system clock and HALF_CYCLES is at least one.
`timescale 1ns/1ns
module osc_half_tick #(
   parameter int HALF_CYCLES = 5
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   // Tick
   output logic      tick_out
);

   logic [15:0] count;

   // ----------------------------------------------------------------
   // Free running divider
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         count    <= 16'h0000;
         tick_out <= 1'b0;
      end else if (count == 16'(HALF_CYCLES - 1)) begin
         count    <= 16'h0000;
         tick_out <= 1'b1;
      end else begin
         count    <= count + 16'h0001;
         tick_out <= 1'b0;
      end
   end

endmodule : osc_half_tick

// File: verilog/ext_bus_seq.sv
// External multiplexed program/data memory bus sequencer.
// Assumes one clock; the requester holds its request until ready drops.
`timescale 1ns/1ns
module ext_bus_seq
   import ext_bus_pkg::*;
#(
   parameter int HALF_PERIOD_CYCLES = HALF_CYCLES
) (
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              reset_n_in,
   // Mode control
   input  wire logic              fast_mode_in,
   input  wire logic              external_exec_in,
   input  wire logic              latch_strobe_suppress_in,
   input  wire logic [WAIT_W-1:0] wait_states_in,
   // Request
   input  wire logic              req_valid_in,
   input  wire logic [1:0]        req_kind_in,
   input  wire logic [ADDR_W-1:0] req_addr_in,
   input  wire logic [DATA_W-1:0] req_wdata_in,
   output logic                   req_ready_out,
   // Answer
   output logic                   resp_valid_out,
   output logic [DATA_W-1:0]      resp_data_out,
   // Bus pins
   output logic                   ale_out,
   output logic                   program_fetch_strobe_n_out,
   output logic                   read_strobe_n_out,
   output logic                   write_strobe_n_out,
   output logic [7:0]             addr_high_out,
   output logic [7:0]             port0_out,
   output logic                   port0_oe_out,
   input  wire logic [7:0]        port0_in
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic              tick;
   bus_state_t        state;
   bus_kind_t         kind;
   logic [HALF_W-1:0] half_count;
   logic [HALF_W-1:0] next_half;
   logic [7:0]        addr_low;
   logic [DATA_W-1:0] wdata;
   logic              use_fast;
   logic              short_ale;
   logic [WAIT_W-1:0] waits;
   logic [7:0]        port0_meta;
   logic [7:0]        port0_sync;
   logic              accept;
   logic              last_half;
   logic              run_tick;

   // Phase marks of the running cycle
   logic [HALF_W-1:0] m_ale_fall;
   logic [HALF_W-1:0] m_addr_off;
   logic [HALF_W-1:0] m_strobe_fall;
   logic [HALF_W-1:0] m_strobe_rise;
   logic [HALF_W-1:0] m_data_off;
   logic [HALF_W-1:0] m_ale_rise;
   logic [HALF_W-1:0] m_end;

   // ----------------------------------------------------------------
   // Phase window decode
   // ----------------------------------------------------------------
   // Shared by the latch strobe and all three bus strobes
   function automatic logic in_span(input logic [HALF_W-1:0] h,
                                    input logic [HALF_W-1:0] from,
                                    input logic [HALF_W-1:0] upto);
      return (h >= from) && (h < upto);
   endfunction : in_span

   // ----------------------------------------------------------------
   // Half period time base
   // ----------------------------------------------------------------
   osc_half_tick #(
      .HALF_CYCLES (HALF_PERIOD_CYCLES)
   ) u_tick (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .tick_out   (tick)
   );

   // ----------------------------------------------------------------
   // Pin input synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         port0_meta <= 8'h00;
         port0_sync <= 8'h00;
      end else begin
         port0_meta <= port0_in;
         port0_sync <= port0_meta;
      end
   end

   // ----------------------------------------------------------------
   // Phase marks
   // ----------------------------------------------------------------
   // Every mark is a half period index, so edges land on half boundaries
   // Wait states stretch data strobes only; the fetch strobe is fixed
   always_comb begin
      m_ale_fall    = short_ale ? ALE_SHORT_HALVES : ALE_HALVES;
      m_addr_off    = m_ale_fall + ADDR_HOLD_HALVES;
      m_strobe_fall = m_addr_off;
      m_strobe_rise = m_addr_off + FETCH_STROBE_HALVES;
      m_data_off    = m_addr_off;
      m_ale_rise    = 5'h1f;
      m_end         = m_strobe_rise;
      if (kind != KIND_FETCH) begin
         if (use_fast) begin
            m_strobe_fall = m_ale_fall + FAST_STROBE_LEAD;
            m_strobe_rise = m_strobe_fall + FAST_STROBE_HALVES
                            + 5'(waits) * WAIT_STATE_HALVES;
            m_data_off    = m_strobe_rise + FAST_DATA_HOLD;
            m_ale_rise    = m_strobe_rise + FAST_ALE_GAP;
         end else begin
            m_strobe_fall = m_ale_fall + COMPAT_STROBE_LEAD;
            m_strobe_rise = m_strobe_fall + COMPAT_STROBE_HALVES
                            + 5'(waits) * WAIT_STATE_HALVES;
            m_data_off    = m_strobe_rise + COMPAT_DATA_HOLD;
            m_ale_rise    = m_strobe_rise + COMPAT_ALE_GAP;
         end
         m_end = m_ale_rise + ALE_TAIL_HALVES - 5'h01;
      end
   end

   assign next_half = half_count + 5'h01;
   assign run_tick  = tick && (state == ST_RUN);
   assign accept    = tick && (state == ST_IDLE) && req_valid_in;
   assign last_half = run_tick && (half_count == m_end);

   // ----------------------------------------------------------------
   // Cycle control
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         state      <= ST_IDLE;
         half_count <= 5'h00;
      end else if (accept) begin
         state      <= ST_RUN;
         half_count <= 5'h00;
      end else if (last_half) begin
         state <= ST_IDLE;
      end else if (run_tick) begin
         half_count <= next_half;
      end
   end

   // ----------------------------------------------------------------
   // Request capture
   // ----------------------------------------------------------------
   // Modes are frozen at the take, so a later change cannot bend a running cycle
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         kind       <= KIND_FETCH;
         use_fast   <= 1'b0;
         short_ale  <= 1'b0;
         waits      <= 2'h0;
         addr_low   <= 8'h00;
         wdata      <= 8'h00;
      end else if (accept) begin
         kind       <= bus_kind_t'(req_kind_in);
         // Data moves during external execution fall back to compat timing
         use_fast   <= fast_mode_in && !(external_exec_in && req_kind_in != KIND_FETCH);
         short_ale  <= fast_mode_in && external_exec_in && !latch_strobe_suppress_in
                       && req_kind_in == KIND_FETCH;
         waits      <= wait_states_in;
         addr_low   <= req_addr_in[7:0];
         wdata      <= req_wdata_in;
      end
   end

   // ----------------------------------------------------------------
   // Requester handshake
   // ----------------------------------------------------------------
   // Ready drops the clock after the take, so the requester sees its request taken
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         req_ready_out <= 1'b0;
      end else begin
         req_ready_out <= (state == ST_IDLE) ? !accept : last_half;
      end
   end

   // ----------------------------------------------------------------
   // Latch strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ale_out <= 1'b0;
      end else if (accept) begin
         ale_out <= 1'b1;
      end else if (last_half) begin
         ale_out <= 1'b0;
      end else if (run_tick) begin
         ale_out <= !in_span(next_half, m_ale_fall, m_ale_rise);
      end
   end

   // ----------------------------------------------------------------
   // High address
   // ----------------------------------------------------------------
   // Held until the next take, which covers the hold after the strobe rise
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         addr_high_out <= 8'h00;
      end else if (accept) begin
         addr_high_out <= req_addr_in[15:8];
      end
   end

   // ----------------------------------------------------------------
   // Multiplexed port drive
   // ----------------------------------------------------------------
   // Write data follows the address without a floating gap; reads float early
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         port0_out    <= 8'h00;
         port0_oe_out <= 1'b0;
      end else if (accept) begin
         port0_out    <= req_addr_in[7:0];
         port0_oe_out <= 1'b1;
      end else if (last_half) begin
         port0_oe_out <= 1'b0;
      end else if (tick && state == ST_RUN) begin
         if (next_half < m_addr_off) begin
            port0_out    <= addr_low;
            port0_oe_out <= 1'b1;
         end else if (kind == KIND_WRITE && next_half < m_data_off) begin
            port0_out    <= wdata;
            port0_oe_out <= 1'b1;
         end else begin
            port0_oe_out <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Strobes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         program_fetch_strobe_n_out <= 1'b1;
         read_strobe_n_out          <= 1'b1;
         write_strobe_n_out         <= 1'b1;
      end else if (run_tick && !last_half) begin
         program_fetch_strobe_n_out <= !(kind == KIND_FETCH
                                         && in_span(next_half, m_strobe_fall, m_strobe_rise));
         read_strobe_n_out          <= !(kind == KIND_READ
                                         && in_span(next_half, m_strobe_fall, m_strobe_rise));
         write_strobe_n_out         <= !(kind == KIND_WRITE
                                         && in_span(next_half, m_strobe_fall, m_strobe_rise));
      end else if (last_half) begin
         program_fetch_strobe_n_out <= 1'b1;
         read_strobe_n_out          <= 1'b1;
         write_strobe_n_out         <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Capture at strobe rise
   // ----------------------------------------------------------------
   // Synchroniser delay means the sample is two clocks older than the edge
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         resp_valid_out <= 1'b0;
         resp_data_out  <= 8'h00;
      end else if (tick && state == ST_RUN && kind != KIND_WRITE
                   && next_half == m_strobe_rise) begin
         resp_valid_out <= 1'b1;
         resp_data_out  <= port0_sync;
      end else begin
         resp_valid_out <= 1'b0;
      end
   end

endmodule : ext_bus_seq

// File: verification/ext_bus_seq_assertions.sv
// Pin timing checks for the external bus sequencer.
// Assumes modes stay steady through each bus cycle.
`timescale 1ns/1ns
module ext_bus_seq_assertions
   import ext_bus_pkg::*;
#(
   parameter int HALF_PERIOD_CYCLES = HALF_CYCLES
) (
   input wire logic              clk_in,
   input wire logic              reset_n_in,
   input wire logic              fast_mode_in,
   input wire logic              external_exec_in,
   input wire logic              latch_strobe_suppress_in,
   input wire logic [WAIT_W-1:0] wait_states_in,
   input wire logic              resp_valid_out,
   input wire logic              ale_out,
   input wire logic              program_fetch_strobe_n_out,
   input wire logic              read_strobe_n_out,
   input wire logic              write_strobe_n_out,
   input wire logic [7:0]        port0_out,
   input wire logic              port0_oe_out
);
   localparam int HP = HALF_PERIOD_CYCLES;
   localparam int D1 = HP - 1;
   localparam int D2 = 2 * HP;
   logic [7:0] c_ale, c_pf, c_d, sf, age, p0_q;
   logic       oe_q;
   wire        pf = program_fetch_strobe_n_out;
   wire        dl = read_strobe_n_out & write_strobe_n_out;
   wire        cm = !fast_mode_in || external_exec_in;
   wire        sh = fast_mode_in && external_exec_in && !latch_strobe_suppress_in;
   // ---------------------------
   // Pulse and age counters
   // ---------------------------
   always_ff @(posedge clk_in) begin
      c_ale <= ale_out ? c_ale + 8'h01 : 8'h00;
      c_pf  <= pf ? 8'h00 : c_pf + 8'h01;
      c_d   <= dl ? 8'h00 : c_d + 8'h01;
      sf    <= ale_out ? 8'h00 : sf + 8'h01;
      age   <= (port0_oe_out && oe_q && port0_out == p0_q) ? age + 8'h01 : 8'h00;
      p0_q  <= port0_out;
      oe_q  <= port0_oe_out;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   a_ale_width: assert property (
      $fell(ale_out) |-> c_ale == D2 || (sh && c_ale == HP)) else $error("latch width");
   a_addr_setup: assert property (
      $fell(ale_out) && port0_oe_out |-> age >= D1) else $error("address setup");
   a_addr_hold: assert property (
      $fell(ale_out) && port0_oe_out |-> ##D1 port0_oe_out && port0_out == $past(port0_out, D1))
      else $error("address hold");
   a_fetch_width: assert property (
      $rose(pf) |-> c_pf == 3 * HP) else $error("fetch width");
   a_fetch_float: assert property (
      $fell(pf) |-> !port0_oe_out) else $error("address float");
   a_data_width: assert property (
      $rose(dl) |-> c_d == ((cm ? 6 : 2) + 2 * wait_states_in) * HP) else $error("data width");
   a_strobe_lead: assert property (
      $fell(dl) |-> sf == (cm ? 3 : 2) * HP) else $error("strobe lead");
   a_wdata_stable: assert property (
      $rose(write_strobe_n_out) |-> port0_oe_out && age >= (cm ? 8 : 3) * HP - 1)
      else $error("write data");
   a_ale_return: assert property (
      $rose(dl) |-> if (cm) ##HP $rose(ale_out) else ##D2 $rose(ale_out))
      else $error("latch return");
   a_read_float: assert property (
      $fell(read_strobe_n_out) |-> !$past(port0_oe_out, HP) && (!cm || !$past(port0_oe_out, D2)))
      else $error("read float");
   a_resp_pulse: assert property (
      $rose(pf) || $rose(read_strobe_n_out) |-> resp_valid_out ##1 !resp_valid_out)
      else $error("response pulse");
endmodule : ext_bus_seq_assertions

bind ext_bus_seq ext_bus_seq_assertions #(.HALF_PERIOD_CYCLES(HALF_PERIOD_CYCLES)) u_chk (
   .clk_in, .reset_n_in, .fast_mode_in, .external_exec_in, .latch_strobe_suppress_in,
   .wait_states_in, .resp_valid_out, .ale_out, .program_fetch_strobe_n_out,
   .read_strobe_n_out, .write_strobe_n_out, .port0_out, .port0_oe_out);

// File: verification/ext_mem_model.sv
// External program and data memory with address latch.
// Assumes the device drives port0 only while its enable is high.
`timescale 1ns/1ns
module ext_mem_model (
   // Clock and pace
   input  wire logic       clk_in,
   input  wire logic       slow_in,
   // Device pins
   input  wire logic       ale_in,
   input  wire logic       fetch_n_in,
   input  wire logic       rd_n_in,
   input  wire logic       wr_n_in,
   input  wire logic [7:0] high_in,
   input  wire logic [7:0] p0_in,
   input  wire logic       oe_in,
   // Resolved port level
   output logic      [7:0] bus_out
);
   logic [7:0] mem [0:255];
   logic [7:0] lat = 8'h00;
   logic [7:0] last = 8'h00;
   logic [2:0] low_cnt = 3'h0;
   logic       ale_q = 1'b0;
   logic       wr_q = 1'b1;
   wire        rd_req = !(fetch_n_in && rd_n_in);
   wire        drive = rd_req && !(slow_in && low_cnt < 3'h2);
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
   // Released port flips each cycle, so stale data never passes
   always_comb bus_out = oe_in ? p0_in : drive ? mem[lat ^ high_in] : ~last;
   always @(posedge clk_in) begin
      last <= bus_out;
      ale_q <= ale_in;
      wr_q <= wr_n_in;
      low_cnt <= !rd_req ? 3'h0 : (low_cnt == 3'h7 ? low_cnt : low_cnt + 3'h1);
      if (ale_q && !ale_in) lat <= bus_out;
      if (!wr_q && wr_n_in) mem[lat ^ high_in] <= bus_out;
   end
endmodule : ext_mem_model

// File: verification/tb_ext_bus_seq.sv
// Testbench for the bus sequencer against the memory model.
// Assumes 100 MHz and a two-clock half oscillator period.
`timescale 1ns/1ns
module tb_ext_bus_seq;
   import ext_bus_pkg::*;
   localparam int HP = 2;
   logic        clk_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic        fast_mode_in = 1'b0, external_exec_in = 1'b0, latch_strobe_suppress_in = 1'b0;
   logic        slow = 1'b0, req_valid_in = 1'b0;
   logic [1:0]  wait_states_in = 2'h0, req_kind_in = 2'h0;
   logic [15:0] req_addr_in = 16'h0000;
   logic [7:0]  req_wdata_in = 8'h00;
   logic [7:0]  shadow [0:255];
   wire         req_ready_out, resp_valid_out, ale_out, port0_oe_out;
   wire         program_fetch_strobe_n_out, read_strobe_n_out, write_strobe_n_out;
   wire  [7:0]  resp_data_out, addr_high_out, port0_out, port0_in;
   int          fails = 0, checks_done = 0, cyc = 0;
   initial forever #5 clk_in = ~clk_in;
   ext_bus_seq #(.HALF_PERIOD_CYCLES(HP)) u_dut (.clk_in, .reset_n_in, .fast_mode_in,
      .external_exec_in, .latch_strobe_suppress_in, .wait_states_in, .req_valid_in,
      .req_kind_in, .req_addr_in, .req_wdata_in, .req_ready_out, .resp_valid_out,
      .resp_data_out, .ale_out, .program_fetch_strobe_n_out, .read_strobe_n_out,
      .write_strobe_n_out, .addr_high_out, .port0_out, .port0_oe_out, .port0_in);
   ext_mem_model u_mem (.clk_in, .slow_in(slow), .ale_in(ale_out),
      .fetch_n_in(program_fetch_strobe_n_out), .rd_n_in(read_strobe_n_out),
      .wr_n_in(write_strobe_n_out), .high_in(addr_high_out), .p0_in(port0_out),
      .oe_in(port0_oe_out), .bus_out(port0_in));
   task automatic conclude;
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   task automatic check(input string nm, input logic [7:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : check
   task automatic mode(input logic f, e, s, sl, input logic [1:0] w);
      @(posedge clk_in);
      fast_mode_in <= f;
      external_exec_in <= e;
      latch_strobe_suppress_in <= s;
      slow <= sl;
      wait_states_in <= w;
   endtask : mode
   // Requester holds valid until ready drops; wid counts strobe-low clocks
   task automatic xfer(input logic [1:0] k, input logic [15:0] a, input logic [7:0] wd,
                       output logic [7:0] d, output int wid);
      int n;
      n = 0;
      wid = 0;
      d = 8'h00;
      do @(posedge clk_in); while (req_ready_out !== 1'b1 && ++n < 40);
      req_kind_in <= k;
      req_addr_in <= a;
      req_wdata_in <= wd;
      req_valid_in <= 1'b1;
      do @(posedge clk_in); while (req_ready_out === 1'b1 && ++n < 80);
      req_valid_in <= 1'b0;
      do begin
         @(posedge clk_in);
         if (!(program_fetch_strobe_n_out && read_strobe_n_out && write_strobe_n_out)) wid++;
         if (resp_valid_out === 1'b1) d = resp_data_out;
      end while (req_ready_out !== 1'b1 && ++n < 300);
      if (req_ready_out !== 1'b1) begin
         fails++;
         $display("unexpected cycle end: expected ready 1, seen %b", req_ready_out);
      end
      repeat (HP) @(posedge clk_in);
   endtask : xfer
   task automatic t_fetch;
      logic [7:0] d;
      int w;
      for (int i = 0; i < 4; i++) begin
         mode(i == 1 || i == 2, i == 1 || i == 2, i == 2, i == 3, 2'h3);
         xfer(KIND_FETCH, 16'h5a10 + 16'(i), 8'h00, d, w);
         check("fetch data", shadow[8'h4a ^ 8'(i)], d);
         check("fetch width", 8'(3 * HP), 8'(w));
      end
      $display("fetch test done");
   endtask : t_fetch
   task automatic t_data(input logic f, e);
      logic [7:0]  d, v;
      logic [15:0] a;
      int          n, s;
      s = (!f || e) ? 6 : 2;
      for (int w = 0; w < 4; w++) begin
         a = {8'hc3, 6'(w), f, e};
         v = 8'h96 ^ a[7:0];
         mode(f, e, 1'b0, !f && w == 3, 2'(w));
         xfer(KIND_WRITE, a, v, d, n);
         check("write width", 8'((s + 2 * w) * HP), 8'(n));
         shadow[a[7:0] ^ a[15:8]] = v;
         xfer(KIND_READ, a, 8'h00, d, n);
         check("read data", v, d);
         check("read width", 8'((s + 2 * w) * HP), 8'(n));
      end
      $display("data test done, fast %b ext %b", f, e);
   endtask : t_data
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      for (int i = 0; i < 256; i++) shadow[i] = 8'(i) ^ 8'h3c;
      repeat (16) @(posedge clk_in);
      reset_n_in <= 1'b1;
      t_fetch();
      t_data(1'b0, 1'b0);
      t_data(1'b1, 1'b0);
      t_data(1'b1, 1'b1);
      conclude();
   end
endmodule : tb_ext_bus_seq
